//--- scpi_pkg.sv
// scpi_pkg: shared constants and types for the sdram command pin interface
// assumes both ends and the connecting interface import it whole
package scpi_pkg;
    // pin widths, bank count and user burst width
    localparam int AW = 16;
    localparam int BW = 3;
    localparam int DW = 16;
    localparam int LANES = 2;
    localparam int NBANK = 8;
    localparam int BURST_W = 128;
    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_ZQ = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    // address bit positions
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    // mode register fields
    localparam int MR0_BL_LSB = 0;
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam int MR1_RTT_B0 = 2;
    localparam int MR1_RTT_B1 = 6;
    localparam int MR1_RTT_B2 = 9;
    localparam int MR1_TDQS_BIT = 11;
    localparam logic [AW-1:0] MR_RST = 16'h0000;
    // latencies in link clock cycles
    localparam logic [3:0] RD_LAT = 4'h5;
    localparam logic [3:0] WR_LAT = 4'h5;
    localparam logic [3:0] BEATS8 = 4'h8;
    localparam logic [3:0] BEATS4 = 4'h4;

    typedef enum logic [3:0] {
        PS_ON = 4'h1,
        PS_PD_PRE = 4'h2,
        PS_PD_ACT = 4'h4,
        PS_SR = 4'h8
    } scpi_pwr_t;

    typedef enum logic [2:0] {
        C_IDLE = 3'h1,
        C_CMD = 3'h2,
        C_BURST = 3'h4
    } scpi_cst_t;

    // beats in a burst from the length field and the chop address bit
    function automatic logic [3:0] scpi_beats(input logic [1:0] bl, input logic a12);
        if (bl == BL_FIX4) begin
            return BEATS4;
        end
        if (bl == BL_OTF && !a12) begin
            return BEATS4;
        end
        return BEATS8;
    endfunction
endpackage

//--- scpi_if.sv
// scpi_if: pins between memory controller and memory device
// assumes the controller end drives ck; bidirectional pins resolved here
`timescale 1ns/1ps
interface scpi_if;
    import scpi_pkg::*;
    logic ck;
    logic reset_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [BW-1:0] ba;
    logic [AW-1:0] addr;
    logic [LANES-1:0] dm;
    logic [DW-1:0] dq_c;
    logic dq_c_oe;
    logic [DW-1:0] dq_d;
    logic dq_d_oe;
    logic [LANES-1:0] dqs_c;
    logic dqs_c_oe;
    logic [LANES-1:0] dqs_d;
    logic dqs_d_oe;
    logic [DW-1:0] dq_w;
    logic [LANES-1:0] dqs_w;

    // wire level from the enables; undriven reads as zero
    assign dq_w = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : '0);
    assign dqs_w = dqs_d_oe ? dqs_d : (dqs_c_oe ? dqs_c : '0);

    modport ctl (
        output ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm,
        output dq_c, dq_c_oe, dqs_c, dqs_c_oe,
        input dq_w, dqs_w
    );
    modport mem (
        input ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm,
        output dq_d, dq_d_oe, dqs_d, dqs_d_oe,
        input dq_w, dqs_w
    );
endinterface

//--- scpi_mem.sv
// scpi_mem: memory device end, command decode, banks, mode registers, data bursts
// assumes link pins change away from the rising ck edge; runs on ck apart from reset and the cke wake marker
// Behaviour
// - activate takes row; read/write take column, A10 (the model keeps no row; activate only marks the bank open)
// - precharge A10 low one bank, high all
// - load mode takes opcode from address pins
// - otf chop: A12 high eight beats, low four
// - bank pins select bank of each access
// - load mode bank pins pick register 0-3
// - all control pins registered on ck rise
// - device read strobes timed from ck edges
// - cke low enters power-down or self refresh
// - cke synchronous except async self refresh exit
// - power-down/self refresh ignore disabled input receivers
// - chip select high masks every command
// - command from cs, ras, cas, we together
// - masked write beat leaves location unchanged
// - termination strobe mode disables lower data mask
// - termination follows registered termination enable pin
// - termination only on data, strobe, mask
// - termination enable ignored when mode disables it
// - reset low, asynchronous assert, release taken at the next ck rise
// - write strobe centred, read strobe edge-aligned
// - bank must be activated before read/write
`timescale 1ns/1ps
module scpi_mem import scpi_pkg::*; (
    scpi_if.mem LINK,
    output logic [3:0] POWER_STATE_OUT,
    output logic [NBANK-1:0] BANK_OPEN_OUT,
    output logic ODT_ON_OUT,
    output logic TDQS_ON_OUT,
    output logic ACCESS_ERR_OUT
);
    typedef struct packed {
        scpi_pwr_t ps;
        logic [3:0][AW-1:0] mr;
        logic [NBANK-1:0] open;
        logic odt_on;
        logic err;
        logic bact;
        logic bwr;
        logic bchop;
        logic bap;
        logic [3:0] wait_c;
        logic [3:0] left;
        logic [2:0] beat;
        logic [BW-1:0] bba;
        logic [3:0] bcol;
        logic [DW-1:0] dq;
        logic dq_oe;
        logic [LANES-1:0] dqs;
        logic dqs_oe;
        logic w1;
        logic w2;
        logic wseen;
    } scpi_mem_st_t;

    scpi_mem_st_t s_r;
    scpi_mem_st_t s_nxt;
    logic wake_tgl_r;
    logic [DW-1:0] mem_r [0:BURST_W-1];
    logic [3:0] cmd;
    logic rtt_en;
    logic tdqs_en;
    logic [2:0] col_lo;
    logic [6:0] idx;
    logic [DW-1:0] rd_word;
    logic [DW-1:0] wr_word;
    logic wr_beat;
    logic [3:0] nbeats;

    // command code from the four command pins sampled together
    assign cmd = {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n};
    assign rtt_en = s_r.mr[1][MR1_RTT_B0] | s_r.mr[1][MR1_RTT_B1] | s_r.mr[1][MR1_RTT_B2];
    assign tdqs_en = s_r.mr[1][MR1_TDQS_BIT];
    assign nbeats = scpi_beats(s_r.mr[0][MR0_BL_LSB+:2], LINK.addr[BC_BIT]);

    // burst address wraps within four or eight columns
    assign col_lo = s_r.bchop ? {s_r.bcol[2], s_r.bcol[1:0] + s_r.beat[1:0]} : s_r.bcol[2:0] + s_r.beat;
    assign idx = {s_r.bba, s_r.bcol[3], col_lo};
    assign rd_word = mem_r[idx];
    assign wr_beat = s_r.bact && s_r.bwr && (s_r.wait_c == 4'h1);

    // per lane merge of write data with old contents under the lane mask
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            logic dm_use;
            assign dm_use = (g == 0) ? !tdqs_en : 1'b1;
            assign wr_word[g*8+:8] = (dm_use && LINK.dm[g]) ? rd_word[g*8+:8] : LINK.dq_w[g*8+:8];
        end
    endgenerate

    // storage array, written one beat per ck rise
    always_ff @(posedge LINK.ck) begin
        if (wr_beat) begin
            mem_r[idx] <= wr_word;
        end
    end

    // self refresh wake marker, toggled by the cke rise with no ck needed
    always_ff @(posedge LINK.cke or negedge LINK.reset_n) begin
        if (!LINK.reset_n) begin
            wake_tgl_r <= 1'b0;
        end else begin
            wake_tgl_r <= ~wake_tgl_r;
        end
    end

    // next state of the device
    always_comb begin
        s_nxt = s_r;
        s_nxt.w1 = wake_tgl_r;
        s_nxt.w2 = s_r.w1;
        s_nxt.dq_oe = 1'b0;
        s_nxt.dqs_oe = 1'b0;
        // termination follows the pin unless mode disables it or the device is in self refresh
        s_nxt.odt_on = LINK.odt && rtt_en && (s_r.ps != PS_SR);
        // burst engine: beats start a fixed latency after the command
        if (s_r.bact) begin
            if (s_r.wait_c != 4'h1) begin
                s_nxt.wait_c = s_r.wait_c - 4'h1;
            end else begin
                if (!s_r.bwr) begin
                    s_nxt.dq = rd_word;
                    s_nxt.dq_oe = 1'b1;
                    s_nxt.dqs = ~s_r.dqs;
                    s_nxt.dqs_oe = 1'b1;
                end
                s_nxt.beat = s_r.beat + 3'h1;
                s_nxt.left = s_r.left - 4'h1;
                if (s_r.left == 4'h1) begin
                    s_nxt.bact = 1'b0;
                    if (s_r.bap) begin
                        s_nxt.open[s_r.bba] = 1'b0;
                    end
                end
            end
        end
        // power state and command decode
        case (s_r.ps)
            PS_ON: begin
                s_nxt.wseen = s_r.w2;
                if (!LINK.cke) begin
                    // entry waits for a running burst to finish
                    if (!s_r.bact) begin
                        if (cmd == CMD_REF) begin
                            s_nxt.ps = PS_SR;
                        end else if (s_r.open == '0) begin
                            s_nxt.ps = PS_PD_PRE;
                        end else begin
                            s_nxt.ps = PS_PD_ACT;
                        end
                    end
                end else if (!LINK.cs_n) begin
                    case (cmd)
                        CMD_ACT: begin
                            s_nxt.open[LINK.ba] = 1'b1;
                        end
                        CMD_PRE: begin
                            if (LINK.addr[AP_BIT]) begin
                                s_nxt.open = '0;
                            end else begin
                                s_nxt.open[LINK.ba] = 1'b0;
                            end
                        end
                        CMD_MRS: begin
                            if (!LINK.ba[2]) begin
                                s_nxt.mr[LINK.ba[1:0]] = LINK.addr;
                            end
                        end
                        CMD_RD, CMD_WR: begin
                            if (!s_r.bact) begin
                                s_nxt.err = s_r.err | !s_r.open[LINK.ba];
                                s_nxt.bact = 1'b1;
                                s_nxt.bwr = (cmd == CMD_WR);
                                s_nxt.bap = LINK.addr[AP_BIT];
                                s_nxt.bba = LINK.ba;
                                s_nxt.bcol = LINK.addr[3:0];
                                s_nxt.left = nbeats;
                                s_nxt.bchop = (nbeats == BEATS4);
                                s_nxt.beat = 3'h0;
                                s_nxt.wait_c = (cmd == CMD_WR) ? WR_LAT : RD_LAT;
                            end
                        end
                        default: begin
                            s_nxt.ps = PS_ON;
                        end
                    endcase
                end
            end
            PS_PD_PRE, PS_PD_ACT: begin
                // only cke and the termination pin are looked at; commands are ignored
                s_nxt.wseen = s_r.w2;
                if (LINK.cke) begin
                    s_nxt.ps = PS_ON;
                end
            end
            PS_SR: begin
                // every pin but cke and reset ignored; exit on the async wake
                if (s_r.w2 != s_r.wseen) begin
                    s_nxt.wseen = s_r.w2;
                    s_nxt.ps = PS_ON;
                end
            end
            default: begin
                s_nxt.ps = PS_ON;
            end
        endcase
    end

    // state register, reset asynchronously when reset falls, released at the next ck rise
    always_ff @(posedge LINK.ck or negedge LINK.reset_n) begin
        if (!LINK.reset_n) begin
            s_r <= '0;
            s_r.ps <= PS_ON;
        end else begin
            s_r <= s_nxt;
        end
    end

    // link and status outputs straight from the state register
    assign LINK.dq_d = s_r.dq;
    assign LINK.dq_d_oe = s_r.dq_oe;
    assign LINK.dqs_d = s_r.dqs;
    assign LINK.dqs_d_oe = s_r.dqs_oe;
    assign POWER_STATE_OUT = s_r.ps;
    assign BANK_OPEN_OUT = s_r.open;
    assign ODT_ON_OUT = s_r.odt_on;
    assign TDQS_ON_OUT = s_r.mr[1][MR1_TDQS_BIT];
    assign ACCESS_ERR_OUT = s_r.err;
endmodule // scpi_mem

//--- scpi_ctl.sv
// scpi_ctl: memory controller end; makes ck as clk/2 and drives commands and data
// assumes user inputs are synchronous to CLK_IN; pins change on ck falls, the write strobe on ck rises
`timescale 1ns/1ps
module scpi_ctl import scpi_pkg::*; (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic REQ_IN,
    input wire logic [3:0] CMD_IN,
    input wire logic [BW-1:0] BA_IN,
    input wire logic [AW-1:0] ADDR_IN,
    input wire logic [BURST_W-1:0] WDATA_IN,
    input wire logic [BURST_W/8-1:0] WMASK_IN,
    input wire logic CKE_IN,
    input wire logic ODT_IN,
    input wire logic MEM_RESETN_IN,
    output logic READY_OUT,
    output logic [BURST_W-1:0] RDATA_OUT,
    output logic RVALID_OUT,
    scpi_if.ctl LINK
);
    typedef struct packed {
        logic ck;
        logic rst_n;
        logic cke;
        logic odt;
        logic [3:0] cmd;
        logic [BW-1:0] ba;
        logic [AW-1:0] addr;
        scpi_cst_t st;
        logic ready;
        logic [3:0] q_cmd;
        logic [BW-1:0] q_ba;
        logic [AW-1:0] q_addr;
        logic [3:0] wait_c;
        logic [3:0] left;
        logic is_wr;
        logic [1:0] bl;
        logic [BURST_W-1:0] wdata;
        logic [BURST_W/8-1:0] wmask;
        logic [BURST_W-1:0] rdata;
        logic rvalid;
        logic [DW-1:0] dq;
        logic dq_oe;
        logic [LANES-1:0] dm;
        logic [LANES-1:0] dqs;
        logic dqs_oe;
    } scpi_ctl_st_t;

    scpi_ctl_st_t s_r;
    scpi_ctl_st_t s_nxt;
    logic q_rw;

    assign q_rw = (s_r.q_cmd == CMD_RD) || (s_r.q_cmd == CMD_WR);

    // next state; s_r.ck high means the coming edge is a ck fall
    always_comb begin
        s_nxt = s_r;
        s_nxt.ck = ~s_r.ck;
        s_nxt.rvalid = 1'b0;
        // accept one request while idle
        if (s_r.st == C_IDLE && REQ_IN && s_r.ready) begin
            s_nxt.ready = 1'b0;
            s_nxt.q_cmd = CMD_IN;
            s_nxt.q_ba = BA_IN;
            s_nxt.q_addr = ADDR_IN;
            s_nxt.wdata = WDATA_IN;
            s_nxt.wmask = WMASK_IN;
            s_nxt.st = C_CMD;
        end
        if (s_r.ck) begin
            // pins move on the fall so they are stable at the rise
            s_nxt.rst_n = MEM_RESETN_IN;
            // a request taken on this fall keeps cke back so its level lands with its command
            if (!(s_r.st == C_IDLE && REQ_IN && s_r.ready)) begin
                s_nxt.cke = CKE_IN;
            end
            s_nxt.odt = ODT_IN;
            s_nxt.cmd = CMD_NOP;
            s_nxt.dq_oe = 1'b0;
            s_nxt.dqs_oe = 1'b0;
            case (s_r.st)
                C_IDLE: begin
                    // a request taken on this fall is issued on the next fall
                end
                C_CMD: begin
                    s_nxt.cmd = s_r.q_cmd;
                    s_nxt.ba = s_r.q_ba;
                    s_nxt.addr = s_r.q_addr;
                    if (s_r.q_cmd == CMD_MRS && s_r.q_ba == 3'h0) begin
                        s_nxt.bl = s_r.q_addr[MR0_BL_LSB+:2];
                    end
                    if (q_rw) begin
                        s_nxt.is_wr = (s_r.q_cmd == CMD_WR);
                        s_nxt.left = scpi_beats(s_r.bl, s_r.q_addr[BC_BIT]);
                        s_nxt.wait_c = (s_r.q_cmd == CMD_WR) ? WR_LAT : RD_LAT + 4'h1;
                        s_nxt.st = C_BURST;
                    end else begin
                        s_nxt.st = C_IDLE;
                        s_nxt.ready = 1'b1;
                    end
                end
                C_BURST: begin
                    if (s_r.wait_c != 4'h1) begin
                        s_nxt.wait_c = s_r.wait_c - 4'h1;
                    end else begin
                        if (s_r.is_wr) begin
                            // one write beat per ck, with its lane masks
                            s_nxt.dq = s_r.wdata[DW-1:0];
                            s_nxt.dm = s_r.wmask[LANES-1:0];
                            s_nxt.dq_oe = 1'b1;
                            s_nxt.dqs_oe = 1'b1;
                            s_nxt.wdata = {{DW{1'b0}}, s_r.wdata[BURST_W-1:DW]};
                            s_nxt.wmask = {{LANES{1'b0}}, s_r.wmask[BURST_W/8-1:LANES]};
                        end else begin
                            // read beat sampled mid-beat, one clk after the ck rise
                            s_nxt.rdata = {LINK.dq_w, s_r.rdata[BURST_W-1:DW]};
                        end
                        s_nxt.left = s_r.left - 4'h1;
                        if (s_r.left == 4'h1) begin
                            s_nxt.st = C_IDLE;
                            s_nxt.ready = 1'b1;
                            s_nxt.rvalid = !s_r.is_wr;
                        end
                    end
                end
                default: begin
                    s_nxt.st = C_IDLE;
                end
            endcase
        end else if (s_r.dq_oe) begin
            // write strobe flips at the ck rise, mid-beat
            s_nxt.dqs = ~s_r.dqs;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            s_r <= '0;
            s_r.st <= C_IDLE;
            s_r.ready <= 1'b1;
            s_r.cmd <= CMD_NOP;
        end else begin
            s_r <= s_nxt;
        end
    end

    // pins and user outputs straight from the state register
    assign LINK.ck = s_r.ck;
    assign LINK.reset_n = s_r.rst_n;
    assign LINK.cke = s_r.cke;
    assign LINK.odt = s_r.odt;
    assign LINK.cs_n = s_r.cmd[3];
    assign LINK.ras_n = s_r.cmd[2];
    assign LINK.cas_n = s_r.cmd[1];
    assign LINK.we_n = s_r.cmd[0];
    assign LINK.ba = s_r.ba;
    assign LINK.addr = s_r.addr;
    assign LINK.dm = s_r.dm;
    assign LINK.dq_c = s_r.dq;
    assign LINK.dq_c_oe = s_r.dq_oe;
    assign LINK.dqs_c = s_r.dqs;
    assign LINK.dqs_c_oe = s_r.dqs_oe;
    assign READY_OUT = s_r.ready;
    assign RDATA_OUT = s_r.rdata;
    assign RVALID_OUT = s_r.rvalid;
endmodule // scpi_ctl

//--- scpi_monitor.sv
// scpi_monitor: assertions on the link pins between the two ends
// assumes the bench instantiates it beside the interface, ports by name
`timescale 1ns/1ps
module scpi_monitor import scpi_pkg::*; (
    input wire logic ck,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic dq_c_oe,
    input wire logic dq_d_oe,
    input wire logic dqs_d_oe,
    input wire logic [LANES-1:0] dqs_d
);
    logic [3:0] run_r; // beats seen in the running read burst

    default clocking cb @(posedge ck); endclocking
    default disable iff (!reset_n);

    // count the device drive cycles of one read burst
    always_ff @(posedge ck) begin
        if (!reset_n || !dq_d_oe) begin
            run_r <= 4'h0;
        end else begin
            run_r <= run_r + 4'h1;
        end
    end

    // commands as decoded at the rising link clock
    sequence rd_cmd;
        cke && {cs_n, ras_n, cas_n, we_n} == CMD_RD;
    endsequence
    sequence wr_cmd;
        cke && {cs_n, ras_n, cas_n, we_n} == CMD_WR;
    endsequence

    a_read_latency: assert property (rd_cmd |-> ##1 !dq_d_oe [*5] ##1 dq_d_oe [*4])
        else $error("read burst not driven at the read latency");
    a_write_beats: assert property (wr_cmd |-> ##1 !dq_c_oe [*4] ##1 dq_c_oe [*4])
        else $error("write beats not launched at the write latency");
    a_write_no_drive: assert property (wr_cmd |=> !dq_d_oe [*8])
        else $error("device drove data after a write command");
    a_strobe_toggle: assert property (dq_d_oe && $past(dq_d_oe) |-> dqs_d == ~$past(dqs_d))
        else $error("read strobe did not toggle each beat");
    a_strobe_with_data: assert property (dq_d_oe == dqs_d_oe)
        else $error("read strobe enable differs from data enable");
    a_burst_length: assert property ($fell(dq_d_oe) |-> run_r == 4'h4 || run_r == 4'h8)
        else $error("read burst length not four or eight");
    a_no_clash: assert property (!(dq_c_oe && dq_d_oe))
        else $error("both ends drive the data lines");
    a_reset_quiet: assert property ($rose(reset_n) |-> !dq_d_oe && !dqs_d_oe)
        else $error("device drives data when reset releases");
endmodule // scpi_monitor

//--- sdram_command_pin_interface_tb.sv
// sdram_command_pin_interface_tb: controller and device joined by the link
// assumes the controller makes the link clock; bench drives the user side
`timescale 1ns/1ps
module sdram_command_pin_interface_tb import scpi_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic cke = 1'b1;
    logic odt = 1'b0;
    logic mrst_n = 1'b1;
    logic [3:0] cmd = CMD_NOP;
    logic [2:0] ba = 3'h0;
    logic [15:0] addr = 16'h0000;
    logic [127:0] wdata = '0;
    logic [15:0] wmask = 16'h0000;
    logic ready, rvalid, odt_on, tdqs_on, aerr;
    logic [127:0] rdata, rd_r, e;
    logic [3:0] pwr;
    logic [7:0] bopen;
    int errors = 0;
    int total_checks = 0;

    scpi_if i_scpi_if ();
    scpi_ctl i_scpi_ctl (.CLK_IN(clk), .RESETN_IN(rst_n), .REQ_IN(req), .CMD_IN(cmd), .BA_IN(ba),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WMASK_IN(wmask), .CKE_IN(cke), .ODT_IN(odt),
        .MEM_RESETN_IN(mrst_n), .READY_OUT(ready), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
        .LINK(i_scpi_if));
    scpi_mem i_scpi_mem (.LINK(i_scpi_if), .POWER_STATE_OUT(pwr), .BANK_OPEN_OUT(bopen),
        .ODT_ON_OUT(odt_on), .TDQS_ON_OUT(tdqs_on), .ACCESS_ERR_OUT(aerr));
    scpi_monitor i_scpi_monitor (.ck(i_scpi_if.ck), .reset_n(i_scpi_if.reset_n), .cke(i_scpi_if.cke),
        .cs_n(i_scpi_if.cs_n), .ras_n(i_scpi_if.ras_n), .cas_n(i_scpi_if.cas_n), .we_n(i_scpi_if.we_n),
        .dq_c_oe(i_scpi_if.dq_c_oe), .dq_d_oe(i_scpi_if.dq_d_oe), .dqs_d_oe(i_scpi_if.dqs_d_oe),
        .dqs_d(i_scpi_if.dqs_d));

    // 40 MHz user clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // burst of eight words counting up from a base
    function automatic logic [127:0] mk(input logic [15:0] b);
        logic [127:0] r;
        for (int i = 0; i < 8; i++) begin
            r[16*i +: 16] = b + 16'(i);
        end
        return r;
    endfunction

    task automatic chk_bit(input string nm, input logic x, input logic g);
        total_checks++;
        if (g !== x) begin
            errors++;
            $display("wrong value %s expected %b seen %b", nm, x, g);
        end
    endtask

    task automatic chk_val(input string nm, input logic [127:0] x, input logic [127:0] g);
        total_checks++;
        if (g !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask

    // one user request with the clock enable level it carries; waits for ready
    task automatic op(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a, input logic k = 1'b1);
        int n;
        @(posedge clk);
        req <= 1'b1;
        cmd <= c;
        ba <= b;
        addr <= a;
        cke <= k;
        @(posedge clk);
        req <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ready !== 1'b1 && n < 400);
        chk_bit("ready", 1'b1, ready);
        // a read that ends without its valid pulse leaves nothing to compare
        rd_r = (rvalid === 1'b1) ? rdata : 'x;
        repeat (8) @(negedge clk);
    endtask

    task automatic wr(input logic [2:0] b, input logic [15:0] a, input logic [127:0] d, input logic [15:0] m);
        @(posedge clk);
        wdata <= d;
        wmask <= m;
        op(CMD_WR, b, a);
    endtask

    // level change on a static pin, then settle
    task automatic set_odt(input logic v);
        @(posedge clk);
        odt <= v;
        repeat (8) @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #400000;
        errors++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        chk_val("power", 128'(PS_ON), 128'(pwr));
        chk_val("banks", 128'h0, 128'(bopen));
        chk_bit("error", 1'b0, aerr);
        $display("test reset done");
        op(CMD_MRS, 3'h1, 16'h0004);
        set_odt(1'b1);
        chk_bit("odt on", 1'b1, odt_on);
        set_odt(1'b0);
        chk_bit("odt off", 1'b0, odt_on);
        set_odt(1'b1);
        op(CMD_MRS, 3'h1, 16'h0800);
        chk_bit("odt ignored", 1'b0, odt_on);
        chk_bit("tdqs", 1'b1, tdqs_on);
        op(CMD_MRS, 3'h1, 16'h0000);
        chk_bit("tdqs off", 1'b0, tdqs_on);
        set_odt(1'b0);
        $display("test modes done");
        op(CMD_MRS, 3'h0, 16'h0001);
        op(CMD_ACT, 3'h3, 16'h0123);
        op(CMD_ACT, 3'h5, 16'h0042);
        chk_val("banks", 128'h28, 128'(bopen));
        wr(3'h3, 16'h1000, mk(16'h1100), 16'h0000);
        wr(3'h3, 16'h1000, mk(16'h2250), 16'h0810);
        e = mk(16'h2250);
        e[39:32] = 8'h02;
        e[95:88] = 8'h11;
        op(CMD_RD, 3'h3, 16'h1000);
        chk_val("masked read", e, rd_r);
        $display("test data done");
        op(CMD_RD, 3'h3, 16'h0002);
        chk_val("chop otf", {64'h0, e[31:0], e[63:32]}, {64'h0, rd_r[127:64]});
        op(CMD_MRS, 3'h0, 16'h0002);
        op(CMD_RD, 3'h3, 16'h1000);
        chk_val("chop fixed", {64'h0, e[63:0]}, {64'h0, rd_r[127:64]});
        op(CMD_MRS, 3'h0, 16'h0000);
        op(CMD_RD, 3'h3, 16'h0000);
        chk_val("fixed eight", e, rd_r);
        $display("test burst done");
        op(4'hB, 3'h0, 16'h0000);
        chk_val("deselect", 128'h28, 128'(bopen));
        wr(3'h0, 16'h1000, mk(16'h3300), 16'h0000);
        chk_bit("closed bank", 1'b1, aerr);
        op(CMD_PRE, 3'h3, 16'h0000);
        chk_val("pre one", 128'h20, 128'(bopen));
        op(CMD_PRE, 3'h0, 16'h0400);
        chk_val("pre all", 128'h0, 128'(bopen));
        $display("test bank done");
        op(CMD_NOP, 3'h0, 16'h0000, 1'b0);
        op(CMD_ACT, 3'h2, 16'h0000, 1'b0);
        chk_val("pd pre", 128'(PS_PD_PRE), 128'(pwr));
        chk_val("pd ignores", 128'h0, 128'(bopen));
        op(CMD_ACT, 3'h1, 16'h0000);
        chk_val("pd exit", 128'(PS_ON), 128'(pwr));
        op(CMD_ACT, 3'h1, 16'h0000);
        op(CMD_NOP, 3'h0, 16'h0000, 1'b0);
        chk_val("pd act", 128'(PS_PD_ACT), 128'(pwr));
        op(CMD_PRE, 3'h0, 16'h0400);
        op(CMD_PRE, 3'h0, 16'h0400);
        chk_val("idle banks", 128'h0, 128'(bopen));
        op(CMD_REF, 3'h0, 16'h0000, 1'b0);
        chk_val("self refresh", 128'(PS_SR), 128'(pwr));
        op(CMD_NOP, 3'h0, 16'h0000);
        repeat (10) @(negedge clk);
        chk_val("sr exit", 128'(PS_ON), 128'(pwr));
        $display("test power done");
        op(CMD_ACT, 3'h6, 16'h0000);
        chk_val("open six", 128'h40, 128'(bopen));
        @(posedge clk);
        mrst_n <= 1'b0;
        repeat (4) @(negedge clk);
        chk_val("reset banks", 128'h0, 128'(bopen));
        @(posedge clk);
        mrst_n <= 1'b1;
        repeat (6) @(negedge clk);
        chk_bit("reset error", 1'b0, aerr);
        $display("test device reset done");
        end_of_test();
    end
endmodule // sdram_command_pin_interface_tb
